//--- hdl/cwsl_loader.sv
// configuration word shadow loader with APB readback
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cwsl_loader (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [23:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sys_reset_req,
    input  wire logic        page_erase,
    input  wire logic [23:0] page_erase_addr,
    output logic             flash_req,
    output logic      [23:0] flash_addr,
    input  wire logic [23:0] flash_rdata,
    input  wire logic        flash_ack,
    output logic             core_reset_n,
    output logic             code_protect,
    output logic      [15:0] sec_cfg,
    output logic      [15:0] bslim_cfg,
    output logic      [15:0] rsvd_cfg,
    output logic      [15:0] oscsel_cfg,
    output logic      [15:0] osc_cfg,
    output logic      [15:0] wdt_cfg,
    output logic      [15:0] por_cfg,
    output logic      [15:0] dbg_cfg
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    cwsl_pkg::cwsl_state_t                                          state_q;
    logic [cwsl_pkg::IDX_W-1:0]                                     idx_q;
    logic [cwsl_pkg::NUM_WORDS-1:0][cwsl_pkg::SHADOW_W-1:0]         cfg_q;
    logic                                                           core_rst_n_q;
    logic                                                           protect_q;
    logic                                                           loaded_q;
    logic                                                           erase_last_q;
    logic                                                           pready_q;
    logic                                                           pslverr_q;
    logic [31:0]                                                    prdata_q;
    logic                                                           rd_done;
    logic [cwsl_pkg::WORD_W-1:0]                                    rd_data;
    logic                                                           setup;
    logic                                                           access;
    logic [3:0]                                                     ridx;
    logic                                                           reload;
    logic [31:0]                                                    rdval;
    logic [cwsl_pkg::SHADOW_W-1:0]                                  rd_masked;

    assign setup  = psel && !penable;
    assign access = psel && penable && pready_q;
    assign ridx   = cwsl_pkg::cwsl_reg_index(paddr);
    assign reload = sys_reset_req
                 || (access && pwrite && ridx == cwsl_pkg::RIDX_CTRL && pwdata[cwsl_pkg::CTRL_RELOAD]);
    assign rd_masked = rd_data[cwsl_pkg::SHADOW_W-1:0] & cwsl_pkg::CFG_IMPL[idx_q];

    cwsl_flash_reader #(
        .AW (cwsl_pkg::ADDR_W),
        .DW (cwsl_pkg::WORD_W)
    ) u_reader (
        .clk          (pclk),
        .rst_n        (presetn),
        .start        (state_q == cwsl_pkg::CWSL_FETCH),
        .addr         (cwsl_pkg::CFG_ADDR[idx_q]),
        .done_q       (rd_done),
        .data_q       (rd_data),
        .flash_req_q  (flash_req),
        .flash_addr_q (flash_addr),
        .flash_rdata  (flash_rdata),
        .flash_ack    (flash_ack)
    );

    // load sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= cwsl_pkg::CWSL_START;
            idx_q   <= '0;
        end else if (reload) begin
            state_q <= cwsl_pkg::CWSL_START;
        end else begin
            case (state_q)
                cwsl_pkg::CWSL_START: begin
                    idx_q   <= '0;
                    // a read cut off by a reload drains first, its word never lands
                    if (!flash_req && !rd_done) begin
                        state_q <= cwsl_pkg::CWSL_FETCH;
                    end
                end
                cwsl_pkg::CWSL_FETCH: begin
                    state_q <= cwsl_pkg::CWSL_WAIT;
                end
                cwsl_pkg::CWSL_WAIT: begin
                    if (rd_done) begin
                        if (idx_q == cwsl_pkg::IDX_W'(cwsl_pkg::NUM_WORDS - 1)) begin
                            state_q <= cwsl_pkg::CWSL_RUN;
                        end else begin
                            idx_q   <= idx_q + 1'b1;
                            state_q <= cwsl_pkg::CWSL_FETCH;
                        end
                    end
                end
                cwsl_pkg::CWSL_RUN: begin
                    state_q <= cwsl_pkg::CWSL_RUN;
                end
                default: begin
                    state_q <= cwsl_pkg::CWSL_START;
                end
            endcase
        end
    end

    // shadow storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= '0;
        end else if (state_q == cwsl_pkg::CWSL_START) begin
            cfg_q <= '0;
        end else if (state_q == cwsl_pkg::CWSL_WAIT && rd_done && !reload) begin
            cfg_q[idx_q] <= rd_masked;
        end
    end

    // core reset release and protection decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_rst_n_q <= 1'b0;
            protect_q    <= 1'b0;
            loaded_q     <= 1'b0;
        end else if (reload || state_q != cwsl_pkg::CWSL_RUN) begin
            core_rst_n_q <= 1'b0;
        end else if (!core_rst_n_q) begin
            core_rst_n_q <= 1'b1;
            loaded_q     <= 1'b1;
            protect_q    <= (cfg_q[cwsl_pkg::IDX_SEC][cwsl_pkg::SEC_GSS_LSB +: 2] != 2'b11)
                         || !cfg_q[cwsl_pkg::IDX_SEC][cwsl_pkg::SEC_GWRP];
        end
    end

    // last page erase seen, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erase_last_q <= 1'b0;
        end else begin
            erase_last_q <= (page_erase && page_erase_addr >= cwsl_pkg::LAST_PAGE_BASE)
                         || (erase_last_q && !(access && pwrite && ridx == cwsl_pkg::RIDX_STAT
                                               && pwdata[cwsl_pkg::STAT_ERASE]));
        end
    end

    // read value; unassigned config word bits up to bit 23 read as one, bits 31:24 and registers other than config words and status read as zero
    always_comb begin
        rdval = '0;
        if (ridx < 4'(cwsl_pkg::NUM_WORDS)) begin
            rdval = {8'h00, cwsl_pkg::UPPER_ONES,
                     cfg_q[ridx[cwsl_pkg::IDX_W-1:0]] | ~cwsl_pkg::CFG_IMPL[ridx[cwsl_pkg::IDX_W-1:0]]};
        end else if (ridx == cwsl_pkg::RIDX_STAT) begin
            rdval[cwsl_pkg::STAT_LOADED] = loaded_q;
            rdval[cwsl_pkg::STAT_ERASE]  = erase_last_q;
            rdval[cwsl_pkg::STAT_BUSY]   = (state_q != cwsl_pkg::CWSL_RUN);
        end
    end

    // apb answer, one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && ridx == cwsl_pkg::RIDX_NONE;
            prdata_q  <= (setup && !pwrite) ? rdval : '0;
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign core_reset_n = core_rst_n_q;
    assign code_protect = protect_q;
    assign sec_cfg      = cfg_q[0];
    assign bslim_cfg    = cfg_q[1];
    assign rsvd_cfg     = cfg_q[2];
    assign oscsel_cfg   = cfg_q[3];
    assign osc_cfg      = cfg_q[4];
    assign wdt_cfg      = cfg_q[5];
    assign por_cfg      = cfg_q[6];
    assign dbg_cfg      = cfg_q[7];

    shadow_clear_a: assert property (state_q == cwsl_pkg::CWSL_START && !reload |=> cfg_q == '0)
        else $error("shadows not cleared at load start");
    load_start_a: assert property (state_q == cwsl_pkg::CWSL_START && !reload && !flash_req && !rd_done
                                   |=> state_q == cwsl_pkg::CWSL_FETCH ##1 flash_req)
        else $error("load did not start after reset");
    upper_drop_a: assert property (state_q == cwsl_pkg::CWSL_WAIT && rd_done && !reload
                                   |=> cfg_q[$past(idx_q)]
                                       == ($past(rd_data[cwsl_pkg::SHADOW_W-1:0]) & cwsl_pkg::CFG_IMPL[$past(idx_q)]))
        else $error("stored shadow does not match masked flash word");
    protect_on_a: assert property (core_rst_n_q && cfg_q[cwsl_pkg::IDX_SEC][cwsl_pkg::SEC_GSS_LSB +: 2] == 2'h0
                                   |-> protect_q)
        else $error("cleared security fields left protection off");
    read_ones_a: assert property (setup && !pwrite && ridx < 4'(cwsl_pkg::NUM_WORDS)
                                  |=> prdata_q[cwsl_pkg::WORD_W-1:cwsl_pkg::SHADOW_W] == cwsl_pkg::UPPER_ONES
                                      && prdata_q[31:cwsl_pkg::WORD_W] == 8'h00)
        else $error("unassigned bits did not read as one");
    reset_hold_a: assert property (core_rst_n_q
                                   |-> state_q == cwsl_pkg::CWSL_RUN
                                       && idx_q == cwsl_pkg::IDX_W'(cwsl_pkg::NUM_WORDS - 1))
        else $error("core reset released before load complete");
    shadow_frozen_a: assert property (core_rst_n_q && $past(core_rst_n_q) |-> $stable(cfg_q))
        else $error("shadow changed while running");
    release_time_a: assert property (state_q == cwsl_pkg::CWSL_WAIT && rd_done && !reload
                                     && idx_q == cwsl_pkg::IDX_W'(cwsl_pkg::NUM_WORDS - 1)
                                     ##1 !reload [*2] |-> core_rst_n_q)
        else $error("core reset not released two cycles after last word");
endmodule // cwsl_loader
`default_nettype wire

//--- common/cwsl_pkg.sv
// package: constants for the configuration word shadow loader
package cwsl_pkg;
    localparam int          NUM_WORDS  = 8;
    localparam int          ADDR_W     = 24;
    localparam int          WORD_W     = 24;
    localparam int          SHADOW_W   = 16;
    localparam int          IDX_W      = 3;
    // flash locations of the configuration words, index order
    localparam logic [NUM_WORDS-1:0][ADDR_W-1:0] CFG_ADDR = {
        24'h0057A8,  // 7 debug_channel_config
        24'h0057A4,  // 6 power_on_reset_config
        24'h0057A0,  // 5 watchdog_config
        24'h00579C,  // 4 oscillator_options_config
        24'h005798,  // 3 oscillator_select_config
        24'h005794,  // 2 reserved_config_word
        24'h005790,  // 1 boot_segment_limit_config
        24'h005780   // 0 code_security_config
    };
    // bits that hold configuration storage in each word
    localparam logic [NUM_WORDS-1:0][SHADOW_W-1:0] CFG_IMPL = {
        16'h0083, 16'h0001, 16'h03FF, 16'h01E7,
        16'h0087, 16'h8000, 16'h1FFF, 16'h8FEF
    };
    localparam logic [ADDR_W-1:0] CTRL_ADDR   = 24'h0057C0;
    localparam logic [ADDR_W-1:0] STAT_ADDR   = 24'h0057C4;
    localparam logic [3:0]        RIDX_CTRL   = 4'h8;
    localparam logic [3:0]        RIDX_STAT   = 4'h9;
    localparam logic [3:0]        RIDX_NONE   = 4'hF;
    localparam int                CTRL_RELOAD = 0;
    localparam int                STAT_LOADED = 0;
    localparam int                STAT_ERASE  = 1;
    localparam int                STAT_BUSY   = 2;
    localparam int                SEC_GSS_LSB = 6;
    localparam int                SEC_GWRP    = 5;
    localparam int                IDX_SEC     = 0;
    localparam logic [7:0]        UPPER_ONES  = 8'hFF;
    localparam logic [ADDR_W-1:0] LAST_PAGE_BASE = 24'h005400;

    typedef enum logic [1:0] {
        CWSL_START = 2'b00,
        CWSL_FETCH = 2'b01,
        CWSL_WAIT  = 2'b11,
        CWSL_RUN   = 2'b10
    } cwsl_state_t;

    // register index of an APB byte address
    function automatic logic [3:0] cwsl_reg_index(input logic [ADDR_W-1:0] a);
        logic [3:0] r;
        r = RIDX_NONE;
        for (int i = 0; i < NUM_WORDS; i++) begin
            if (a == CFG_ADDR[i]) begin
                r = 4'(i);
            end
        end
        if (a == CTRL_ADDR) begin
            r = RIDX_CTRL;
        end
        if (a == STAT_ADDR) begin
            r = RIDX_STAT;
        end
        return r;
    endfunction
endpackage

//--- hdl/cwsl_flash_reader.sv
// flash read port: one word per start, request held until acknowledged
`timescale 1ns/1ps
`default_nettype none
module cwsl_flash_reader #(
    parameter int AW = 24,
    parameter int DW = 24
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          start,
    input  wire logic [AW-1:0] addr,
    output logic               done_q,
    output logic      [DW-1:0] data_q,
    output logic               flash_req_q,
    output logic      [AW-1:0] flash_addr_q,
    input  wire logic [DW-1:0] flash_rdata,
    input  wire logic          flash_ack
);
    if (DW < cwsl_pkg::SHADOW_W) begin : g_chk
        $error("flash word narrower than shadow word");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_req_q  <= 1'b0;
            flash_addr_q <= '0;
            done_q       <= 1'b0;
            data_q       <= '0;
        end else begin
            done_q <= 1'b0;
            if (start && !flash_req_q) begin
                flash_req_q  <= 1'b1;
                flash_addr_q <= addr;
            end else if (flash_req_q && flash_ack) begin
                flash_req_q <= 1'b0;
                done_q      <= 1'b1;
                data_q      <= flash_rdata;
            end
        end
    end
endmodule // cwsl_flash_reader
`default_nettype wire

//--- testbench/cwsl_flash_model.sv
// flash model: configuration locations answering the loader's read port
`timescale 1ns/1ps
`default_nettype none
module cwsl_flash_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        req,
    input  wire logic [23:0] addr,
    input  wire logic [1:0]  delay,
    input  wire logic        erase,
    input  wire logic [23:0] erase_addr,
    output logic      [23:0] rdata,
    output logic             ack
);
    logic [23:0] mem [8];
    logic [1:0]  wait_q;
    logic [23:0] word;
    always_comb begin
        word = 24'hFFFFFF;
        for (int i = 0; i < 8; i++) begin
            if (addr == cwsl_pkg::CFG_ADDR[i]) begin
                word = mem[i];
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack    <= 1'b0;
            wait_q <= 2'h0;
            rdata  <= 24'hA5A5A5;
        end else if (req && !ack && wait_q == delay) begin
            ack    <= 1'b1;
            wait_q <= 2'h0;
            rdata  <= word;
        end else begin
            ack    <= 1'b0;
            wait_q <= (req && !ack) ? wait_q + 2'h1 : 2'h0;
            rdata  <= ~rdata;  // inverted each cycle outside the answer, so the last word shows again every second cycle
        end
    end
    always @(posedge clk) begin
        if (erase && erase_addr >= cwsl_pkg::LAST_PAGE_BASE) begin
            for (int i = 0; i < 8; i++) begin
                mem[i] <= 24'h000000;
            end
        end
    end
endmodule  // cwsl_flash_model
`default_nettype wire

//--- testbench/testbench.sv
// testbench: loader against flash model, APB readback checks
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic             pclk = 1'b0;
    logic             presetn = 1'b0;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic      [23:0] paddr = 24'h0;
    logic      [31:0] pwdata = 32'h0;
    logic             sys_reset_req = 1'b0;
    logic             page_erase = 1'b0;
    logic      [23:0] page_erase_addr = 24'h0;
    logic      [1:0]  delay = 2'h0;
    wire logic [31:0] prdata;
    wire logic        pready, pslverr, flash_req, flash_ack, core_reset_n, code_protect;
    wire logic [23:0] flash_addr, flash_rdata;
    wire logic [7:0][15:0] sh;
    logic [7:0][23:0] ld;
    logic      [33:0] exp_q[$];
    logic      [23:0] fa_q[$];
    logic      [33:0] e;
    int               fails = 0;
    int               cmp_count = 0;
    always #5 pclk = ~pclk;
    cwsl_loader i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sys_reset_req(sys_reset_req), .page_erase(page_erase), .page_erase_addr(page_erase_addr),
        .flash_req(flash_req), .flash_addr(flash_addr), .flash_rdata(flash_rdata), .flash_ack(flash_ack),
        .core_reset_n(core_reset_n), .code_protect(code_protect), .sec_cfg(sh[0]), .bslim_cfg(sh[1]),
        .rsvd_cfg(sh[2]), .oscsel_cfg(sh[3]), .osc_cfg(sh[4]), .wdt_cfg(sh[5]), .por_cfg(sh[6]), .dbg_cfg(sh[7]));
    cwsl_flash_model i_flash (.clk(pclk), .rst_n(presetn), .req(flash_req), .addr(flash_addr), .delay(delay),
        .erase(page_erase), .erase_addr(page_erase_addr), .rdata(flash_rdata), .ack(flash_ack));
    task automatic cmp(input logic [31:0] got, input logic [31:0] want, input string m);
        cmp_count++;
        if (got !== want) begin
            fails++;
            $display("unexpected %0t %s got %h want %h", $time, m, got, want);
        end
    endtask
    always @(posedge pclk) begin
        if (flash_req === 1'b1 && flash_ack === 1'b1) begin
            cmp(flash_addr, fa_q.size() > 0 ? fa_q.pop_front() : 24'h0, "flash order");
        end
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 34'h0;
            cmp(pslverr, e[32], "apb error");
            if (!e[33]) cmp(prdata, e[31:0], "apb data");
        end
    end
    task automatic apb(input logic w, input logic [23:0] a, input logic [31:0] d, input logic [33:0] x);
        exp_q.push_back(x);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic fill(input logic k);
        for (int i = 0; i < 8; i++) begin
            i_flash.mem[i] = {8'hFF, 16'($urandom)};
        end
        i_flash.mem[2][15] = 1'b0;
        i_flash.mem[7][7] = 1'b1;
        if (k) i_flash.mem[0][7:5] = 3'b111;
        delay <= 2'($urandom);
    endtask
    task automatic check(input int t);
        logic [15:0] s;
        for (int i = 0; i < 8; i++) begin
            s = ld[i][15:0] & cwsl_pkg::CFG_IMPL[i];
            cmp(sh[i], s, "shadow");
            apb(1'b0, cwsl_pkg::CFG_ADDR[i], 32'h0, {10'h0FF, s | ~cwsl_pkg::CFG_IMPL[i]});
        end
        s = ld[0][15:0];
        cmp(code_protect, (s[7:6] != 2'b11) || !s[5], "protect");
        apb(1'b0, cwsl_pkg::STAT_ADDR, 32'h0, 34'h1);
        $display("test %0d done", t);
    endtask
    task automatic go(input int kind);
        for (int i = 0; i < 8; i++) begin
            fa_q.push_back(cwsl_pkg::CFG_ADDR[i]);
            ld[i] = i_flash.mem[i];
        end
        if (kind == 0) begin
            presetn <= 1'b0;
            repeat (5) @(posedge pclk);
            presetn <= 1'b1;
        end else if (kind == 1) begin
            apb(1'b1, cwsl_pkg::CTRL_ADDR, 32'h1, {2'b10, 32'h0});
        end else begin
            sys_reset_req <= 1'b1;
            @(posedge pclk);
            sys_reset_req <= 1'b0;
        end
        while (core_reset_n !== 1'b0) @(posedge pclk);
        @(posedge pclk);
        cmp(|sh, 1'b0, "shadow clear");
        while (core_reset_n !== 1'b1) @(posedge pclk);
        cmp(fa_q.size(), 0, "early release");
        check(kind);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        $display("unexpected %0t watchdog", $time);
        summarize();
    end
    initial begin
        void'($urandom(32'hC7526031));
        @(posedge pclk);
        fill(1'b1);
        go(0);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, cwsl_pkg::CFG_ADDR[i], 32'hFFFFFFFF, {2'b10, 32'h0});
        end
        apb(1'b0, 24'h0057C8, 32'h0, {2'b01, 32'h0});
        apb(1'b1, 24'h0057C8, 32'h1, {2'b11, 32'h0});
        apb(1'b0, cwsl_pkg::CTRL_ADDR, 32'h0, 34'h0);
        fill(1'b0);
        repeat (20) @(posedge pclk);
        check(9);
        for (int k = 0; k < 3; k++) begin
            fill(k == 1);
            go(k);
        end
        page_erase_addr <= cwsl_pkg::LAST_PAGE_BASE - 24'h4;
        page_erase <= 1'b1;
        @(posedge pclk);
        page_erase <= 1'b0;
        apb(1'b0, cwsl_pkg::STAT_ADDR, 32'h0, 34'h1);
        page_erase_addr <= cwsl_pkg::LAST_PAGE_BASE;
        page_erase <= 1'b1;
        @(posedge pclk);
        page_erase <= 1'b0;
        apb(1'b0, cwsl_pkg::STAT_ADDR, 32'h0, 34'h3);
        apb(1'b1, cwsl_pkg::STAT_ADDR, 32'h2, {2'b10, 32'h0});
        go(1);
        summarize();
    end
endmodule  // testbench
`default_nettype wire
